/* File: src/aui_alarm_update_irq.sv */
`timescale 1ns/1ps
module aui_alarm_update_irq #(
    parameter int UPD_RELEASE_CYCLES = aui_pkg::UPD_RELEASE_CYC
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic [aui_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [aui_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [aui_pkg::DATA_W-1:0] reg_rdata_out,
    input wire logic [6:0] time_sec_in,
    input wire logic [6:0] time_min_in,
    input wire logic [5:0] time_hour_in,
    input wire logic [5:0] time_mday_in,
    input wire logic [6:0] time_wday_in,
    input wire logic sec_inc_in,
    input wire logic min_inc_in,
    output logic int_n_out,
    output logic int_n_oe_out,
    output logic irq_out
);
    logic [7:0] alarm_sec_reg;
    logic [7:0] alarm_min_reg;
    logic [7:0] alarm_hour_reg;
    logic [7:0] alarm_day_reg;
    logic [7:0] ctrl_reg;
    logic alarm_flag_reg;
    logic update_event_flag_reg;
    logic [1:0] irq_stat_reg;
    logic [1:0] irq_mask_reg;
    logic [7:0] rdata_reg;
    logic match_prev_reg;
    logic upd_low_reg;
    logic [aui_pkg::UPD_CNT_W-1:0] upd_cnt_reg;
    logic oe_reg;
    logic oe_next;
    logic update_irq_enable;
    logic alarm_irq_enable;
    logic update_period_select;
    logic weekday_or_monthday_select;
    logic sec_ok;
    logic min_ok;
    logic hour_ok;
    logic day_ok;
    logic alarm_match;
    logic alarm_evt;
    logic upd_evt;
    logic wr_flag;
    logic rd_stat;

    // A field matches when ignored or when its value equals the count.
    function automatic logic field_ok(input logic [7:0] fld, input logic [6:0] now);
        field_ok = fld[aui_pkg::IGNORE_BIT] || (fld[6:0] == now);
    endfunction

    function automatic logic is_wr(input logic [3:0] a, input logic [3:0] target);
        is_wr = (a == target);
    endfunction

    assign update_irq_enable = ctrl_reg[aui_pkg::CTRL_UIE_BIT];
    assign alarm_irq_enable = ctrl_reg[aui_pkg::CTRL_AIE_BIT];
    assign update_period_select = ctrl_reg[aui_pkg::CTRL_UPDATE_PERIOD_SELECT_BIT];
    assign weekday_or_monthday_select = ctrl_reg[aui_pkg::CTRL_WEEKDAY_OR_MONTHDAY_SELECT_BIT];

    assign sec_ok = field_ok(alarm_sec_reg, time_sec_in);
    assign min_ok = field_ok(alarm_min_reg, time_min_in);
    assign hour_ok = field_ok(alarm_hour_reg, {1'b0, time_hour_in});

    // In weekday mode the low seven bits are a day mask, so one alarm can cover several days.
    always_comb begin
        if (alarm_day_reg[aui_pkg::IGNORE_BIT]) begin
            day_ok = 1'b1;
        end else if (weekday_or_monthday_select) begin
            day_ok = (alarm_day_reg[5:0] == time_mday_in) && !alarm_day_reg[6];
        end else begin
            day_ok = |(alarm_day_reg[6:0] & time_wday_in);
        end
    end

    assign alarm_match = sec_ok && min_ok && hour_ok && day_ok;
    // The alarm fires on entry into a match, so an ignored seconds field gives one event, not one per second, in a matching minute.
    assign alarm_evt = alarm_match && !match_prev_reg;
    assign upd_evt = update_period_select ? min_inc_in : sec_inc_in;

    assign wr_flag = reg_wr_in && is_wr(reg_addr_in, aui_pkg::FLAG_ADDR);
    assign rd_stat = reg_rd_in && is_wr(reg_addr_in, aui_pkg::IRQ_STAT_ADDR);

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            // Fields reset to ignored, so a match is the idle state and starting high avoids a false alarm.
            match_prev_reg <= 1'b1;
        end else begin
            match_prev_reg <= alarm_match;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            alarm_sec_reg <= aui_pkg::ALARM_RST;
            alarm_min_reg <= aui_pkg::ALARM_RST;
            alarm_hour_reg <= aui_pkg::ALARM_RST;
            alarm_day_reg <= aui_pkg::ALARM_RST;
            ctrl_reg <= aui_pkg::CTRL_RST;
            irq_mask_reg <= aui_pkg::MASK_RST[1:0];
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                aui_pkg::ALARM_SEC_ADDR: begin
                    alarm_sec_reg <= reg_wdata_in;
                end
                aui_pkg::ALARM_MIN_ADDR: begin
                    alarm_min_reg <= reg_wdata_in;
                end
                aui_pkg::ALARM_HOUR_ADDR: begin
                    alarm_hour_reg <= reg_wdata_in;
                end
                aui_pkg::ALARM_DAY_ADDR: begin
                    alarm_day_reg <= reg_wdata_in;
                end
                aui_pkg::CTRL_ADDR: begin
                    ctrl_reg <= {4'h0, reg_wdata_in[3:0]};
                end
                aui_pkg::IRQ_MASK_ADDR: begin
                    irq_mask_reg <= reg_wdata_in[1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Writing one to a flag is ignored; a new event in the clearing cycle keeps the flag set.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            alarm_flag_reg <= 1'b0;
            update_event_flag_reg <= 1'b0;
        end else begin
            if (alarm_evt) begin
                alarm_flag_reg <= 1'b1;
            end else if (wr_flag && !reg_wdata_in[aui_pkg::FLAG_ALARM_BIT]) begin
                alarm_flag_reg <= 1'b0;
            end
            if (upd_evt) begin
                update_event_flag_reg <= 1'b1;
            end else if (wr_flag && !reg_wdata_in[aui_pkg::FLAG_UPD_BIT]) begin
                update_event_flag_reg <= 1'b0;
            end
        end
    end

    // Update drive: held low for the release time, cut short by clearing the flag or the enable.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            upd_low_reg <= 1'b0;
            upd_cnt_reg <= '0;
        end else if (upd_evt && update_irq_enable) begin
            upd_low_reg <= 1'b1;
            upd_cnt_reg <= aui_pkg::UPD_CNT_W'(UPD_RELEASE_CYCLES);
        end else if (!update_irq_enable || (wr_flag && !reg_wdata_in[aui_pkg::FLAG_UPD_BIT])) begin
            upd_low_reg <= 1'b0;
            upd_cnt_reg <= '0;
        end else if (upd_low_reg) begin
            upd_cnt_reg <= upd_cnt_reg - 1'b1;
            if (upd_cnt_reg == aui_pkg::UPD_CNT_W'(1)) begin
                upd_low_reg <= 1'b0;
            end
        end
    end

    assign oe_next = upd_low_reg || (alarm_flag_reg && alarm_irq_enable);

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            oe_reg <= 1'b0;
        end else begin
            oe_reg <= oe_next;
        end
    end

    // The pin only ever sinks current; the pull-up sits outside.
    assign int_n_out = 1'b0;
    assign int_n_oe_out = oe_reg;

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            irq_stat_reg <= 2'h0;
        end else begin
            irq_stat_reg[aui_pkg::IRQ_ALARM_BIT] <= alarm_evt || (irq_stat_reg[aui_pkg::IRQ_ALARM_BIT] && !rd_stat);
            irq_stat_reg[aui_pkg::IRQ_UPD_BIT] <= upd_evt || (irq_stat_reg[aui_pkg::IRQ_UPD_BIT] && !rd_stat);
        end
    end

    assign irq_out = |(irq_stat_reg & irq_mask_reg);

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            rdata_reg <= 8'h00;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                aui_pkg::ALARM_SEC_ADDR: begin
                    rdata_reg <= alarm_sec_reg;
                end
                aui_pkg::ALARM_MIN_ADDR: begin
                    rdata_reg <= alarm_min_reg;
                end
                aui_pkg::ALARM_HOUR_ADDR: begin
                    rdata_reg <= alarm_hour_reg;
                end
                aui_pkg::ALARM_DAY_ADDR: begin
                    rdata_reg <= alarm_day_reg;
                end
                aui_pkg::CTRL_ADDR: begin
                    rdata_reg <= ctrl_reg;
                end
                aui_pkg::FLAG_ADDR: begin
                    rdata_reg <= {5'h00, oe_reg, update_event_flag_reg, alarm_flag_reg};
                end
                aui_pkg::IRQ_STAT_ADDR: begin
                    rdata_reg <= {6'h00, irq_stat_reg};
                end
                aui_pkg::IRQ_MASK_ADDR: begin
                    rdata_reg <= {6'h00, irq_mask_reg};
                end
                default: begin
                    rdata_reg <= 8'h00;
                end
            endcase
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    assign reg_rdata_out = rdata_reg;

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (reset_in);

    // Length of the current low phase of the update drive, for the release check.
    logic [aui_pkg::UPD_CNT_W-1:0] low_len_reg;

    always_ff @(posedge core_clk_in) begin
        // A new enabled event restarts the drive, so the length count restarts with it.
        if (reset_in || !upd_low_reg || (upd_evt && update_irq_enable)) begin
            low_len_reg <= '0;
        end else begin
            low_len_reg <= low_len_reg + 1'b1;
        end
    end

    sec_ignore_a: assert property (
        alarm_sec_reg[7] && min_ok && hour_ok && day_ok |-> alarm_match)
        else $error("seconds ignore did not hold the match");

    hour_ignore_a: assert property (
        alarm_hour_reg[7] && sec_ok && min_ok && day_ok |-> alarm_match)
        else $error("hour ignore did not match in this hour");

    mday_compare_a: assert property (
        weekday_or_monthday_select && !alarm_day_reg[7] && alarm_day_reg[6:0] != {1'b0, time_mday_in}
        |-> !alarm_match)
        else $error("day of month mismatch still matched");

    day_ignore_a: assert property (
        alarm_day_reg[7] && sec_ok && min_ok && hour_ok && !match_prev_reg
        |=> alarm_flag_reg)
        else $error("daily alarm did not raise its flag");

    upd_source_a: assert property (
        update_period_select && sec_inc_in && !min_inc_in && !update_event_flag_reg
        |=> !update_event_flag_reg)
        else $error("second tick flagged in minute mode");

    upd_flag_set_a: assert property (
        (update_period_select ? min_inc_in : sec_inc_in) |=> update_event_flag_reg && irq_stat_reg[1])
        else $error("update event not recorded");

    upd_flag_hold_a: assert property (
        update_event_flag_reg && !(wr_flag && !reg_wdata_in[1]) |=> update_event_flag_reg)
        else $error("update flag lost without a clear");

    upd_enable_a: assert property (
        $rose(upd_low_reg) |-> $past(update_irq_enable) && $past(upd_evt))
        else $error("update drive without enable");

    upd_release_a: assert property (
        upd_low_reg && low_len_reg == aui_pkg::UPD_CNT_W'(UPD_RELEASE_CYCLES - 1) |=> !upd_low_reg)
        else $error("update drive not released in time");

    upd_min_len_a: assert property (
        $fell(upd_low_reg) && $past(update_irq_enable) && !$past(wr_flag) && !$past(upd_evt)
        |-> $past(low_len_reg) == aui_pkg::UPD_CNT_W'(UPD_RELEASE_CYCLES - 1))
        else $error("update drive released early");

    pin_drive_a: assert property (
        (alarm_flag_reg && alarm_irq_enable) || upd_low_reg |=> int_n_oe_out && !int_n_out)
        else $error("interrupt pin not pulled low");

    irq_level_a: assert property (
        irq_out |-> ##1 (irq_out || $past(rd_stat) || $past(reg_wr_in)))
        else $error("interrupt output dropped on its own");

    upd_clear_a: assert property (
        wr_flag && !reg_wdata_in[aui_pkg::FLAG_UPD_BIT] && !upd_evt |=> !update_event_flag_reg)
        else $error("update flag clear did not take effect");

    upd_cancel_a: assert property (
        wr_flag && !reg_wdata_in[aui_pkg::FLAG_UPD_BIT] && !upd_evt |=> !upd_low_reg)
        else $error("flag clear did not cancel the update drive");

    upd_no_drive_a: assert property (
        upd_evt && !update_irq_enable |=> !upd_low_reg && update_event_flag_reg)
        else $error("disabled update event drove the pin or lost its flag");

    wday_mask_a: assert property (
        !weekday_or_monthday_select && !alarm_day_reg[aui_pkg::IGNORE_BIT]
        && (alarm_day_reg[6:0] & time_wday_in) == 7'h00 |-> !alarm_match)
        else $error("weekday outside the mask still matched");

    alarm_set_a: assert property (
        alarm_evt |=> alarm_flag_reg && irq_stat_reg[aui_pkg::IRQ_ALARM_BIT])
        else $error("alarm event not recorded");

    alarm_clear_a: assert property (
        wr_flag && !reg_wdata_in[aui_pkg::FLAG_ALARM_BIT] && !alarm_evt |=> !alarm_flag_reg)
        else $error("alarm flag clear did not take effect");

    stat_clear_a: assert property (
        rd_stat && !alarm_evt && !upd_evt |=> irq_stat_reg == 2'h0)
        else $error("status read did not clear the status");

    monthday_hourly_c: cover property (
        weekday_or_monthday_select && alarm_hour_reg[7] && alarm_evt);
    daily_alarm_c: cover property (alarm_day_reg[7] && alarm_evt ##1 int_n_oe_out);
    upd_timeout_c: cover property ($fell(upd_low_reg) && update_event_flag_reg);
    clear_race_c: cover property (wr_flag && upd_evt);
    weekday_alarm_c: cover property (!weekday_or_monthday_select && !alarm_day_reg[7] && alarm_evt);
endmodule

/* File: src/aui_pkg.sv */
package aui_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    // Register byte addresses.
    localparam logic [3:0] ALARM_SEC_ADDR = 4'h0;
    localparam logic [3:0] ALARM_MIN_ADDR = 4'h1;
    localparam logic [3:0] ALARM_HOUR_ADDR = 4'h2;
    localparam logic [3:0] ALARM_DAY_ADDR = 4'h3;
    localparam logic [3:0] CTRL_ADDR = 4'h4;
    localparam logic [3:0] FLAG_ADDR = 4'h5;
    localparam logic [3:0] IRQ_STAT_ADDR = 4'h6;
    localparam logic [3:0] IRQ_MASK_ADDR = 4'h7;
    // Alarm field layout: bit 7 removes the field from the comparison.
    localparam int IGNORE_BIT = 7;
    // Control register bits.
    localparam int CTRL_UIE_BIT = 0;
    localparam int CTRL_AIE_BIT = 1;
    localparam int CTRL_UPDATE_PERIOD_SELECT_BIT = 2;
    localparam int CTRL_WEEKDAY_OR_MONTHDAY_SELECT_BIT = 3;
    // Flag register bits; bit 2 is the read-only pin state.
    localparam int FLAG_ALARM_BIT = 0;
    localparam int FLAG_UPD_BIT = 1;
    localparam int FLAG_PIN_BIT = 2;
    // Interrupt status and mask bits.
    localparam int IRQ_ALARM_BIT = 0;
    localparam int IRQ_UPD_BIT = 1;
    localparam logic [7:0] ALARM_RST = 8'h80;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    // Automatic release time of the update interrupt, least time.
    localparam real UPD_RELEASE_MS = 7.57;
    localparam real CLK_FREQ_MHZ = 25.0;
    localparam int UPD_RELEASE_CYC = int'($ceil(UPD_RELEASE_MS * 1000.0 * CLK_FREQ_MHZ));
    localparam int UPD_CNT_W = 18;
endpackage

/* File: testbench/aui_host_model.sv */
`timescale 1ns/1ps
module aui_host_model (
    input wire logic int_n_in,
    input wire logic int_n_oe_in,
    output logic pin_level_out
);
    // The host line carries a pull-up, so a released pin reads high and never keeps the last driven level.
    assign pin_level_out = int_n_oe_in ? int_n_in : 1'b1;
endmodule

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
    localparam int REL = 20;
    logic core_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [3:0] reg_addr_in = 4'h0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic sec_inc_in = 1'b0;
    logic min_inc_in = 1'b0;
    logic [6:0] time_sec_in = 7'h00;
    logic [6:0] time_min_in = 7'h00;
    logic [6:0] time_wday_in = 7'h01;
    logic [5:0] time_hour_in = 6'h00;
    logic [5:0] time_mday_in = 6'h01;
    logic [7:0] reg_rdata_out;
    logic [7:0] rdata;
    logic int_n_out;
    logic int_n_oe_out;
    logic irq_out;
    logic pin;
    int failures = 0;
    int total_checks = 0;
    int cyc = 0;
    int al[4] = '{32'h80, 32'h80, 32'h80, 32'h80};
    logic [7:0] ctl = 8'h00;
    bit af = 1'b0;
    bit uf = 1'b0;
    bit pm = 1'b1;

    aui_alarm_update_irq #(.UPD_RELEASE_CYCLES(REL)) i_aui_alarm_update_irq (
        .core_clk_in(core_clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .time_sec_in(time_sec_in), .time_min_in(time_min_in),
        .time_hour_in(time_hour_in), .time_mday_in(time_mday_in), .time_wday_in(time_wday_in),
        .sec_inc_in(sec_inc_in), .min_inc_in(min_inc_in), .int_n_out(int_n_out),
        .int_n_oe_out(int_n_oe_out), .irq_out(irq_out));
    aui_host_model i_aui_host_model (.int_n_in(int_n_out), .int_n_oe_in(int_n_oe_out), .pin_level_out(pin));

    always #20 core_clk_in = ~core_clk_in;

    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: expected %0h got %0h", $time, exp, got);
        end
    endtask

    task automatic chk_pin(input logic exp);
        chk({7'h00, exp}, {7'h00, pin});
    endtask

    // Model of the alarm comparison; an event is raised only on entry into a match.
    task automatic upd_m();
        bit m;
        m = (al[0][7] || al[0][6:0] == time_sec_in) && (al[1][7] || al[1][6:0] == time_min_in);
        m = m && (al[2][7] || al[2][6:0] == {1'b0, time_hour_in});
        m = m && (al[3][7] || (ctl[3] ? al[3][6:0] == {1'b0, time_mday_in} : (al[3][6:0] & time_wday_in) != 0));
        if (m && !pm) af = 1'b1;
        pm = m;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
        if (a < 4'h4) al[a] = d;
        if (a == aui_pkg::CTRL_ADDR) ctl = d;
        if (a == aui_pkg::FLAG_ADDR && !d[0]) af = 1'b0;
        if (a == aui_pkg::FLAG_ADDR && !d[1]) uf = 1'b0;
        upd_m();
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge core_clk_in);
        reg_rd_in <= 1'b0;
        #1 rdata = reg_rdata_out;
    endtask

    task automatic chk_state();
        rd(aui_pkg::FLAG_ADDR);
        chk({6'h00, uf, af}, rdata & 8'h03);
        chk_pin(!(af && ctl[1]));
    endtask

    task automatic st(input logic [6:0] s, input logic [6:0] m, input logic [6:0] h, input logic [6:0] d);
        @(posedge core_clk_in);
        time_sec_in <= s;
        time_min_in <= m;
        time_hour_in <= h[5:0];
        time_mday_in <= d[5:0];
        time_wday_in <= 7'h01 << ($urandom % 7);
        @(posedge core_clk_in);
        upd_m();
        repeat (2) @(posedge core_clk_in);
        chk_state();
        wr(aui_pkg::FLAG_ADDR, 8'h00);
    endtask

    task automatic acase(input logic [7:0] s, input logic [7:0] m, input logic [7:0] h, input logic [7:0] d);
        wr(aui_pkg::FLAG_ADDR, 8'h00);
        wr(aui_pkg::ALARM_SEC_ADDR, s);
        wr(aui_pkg::ALARM_MIN_ADDR, m);
        wr(aui_pkg::ALARM_HOUR_ADDR, h);
        wr(aui_pkg::ALARM_DAY_ADDR, d);
    endtask

    task automatic tick(input bit minute);
        @(posedge core_clk_in);
        sec_inc_in <= !minute;
        min_inc_in <= minute;
        @(posedge core_clk_in);
        sec_inc_in <= 1'b0;
        min_inc_in <= 1'b0;
        if (minute == ctl[2]) uf = 1'b1;
    endtask

    function automatic logic [6:0] bcd(input int v);
        return 7'((v / 10) * 16 + v % 10);
    endfunction

    initial begin
        int h1;
        h1 = $urandom(38);
        repeat (12) @(posedge core_clk_in);
        reset_in <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            rd(4'(i));
            chk(aui_pkg::ALARM_RST, rdata);
        end
        rd(aui_pkg::CTRL_ADDR);
        chk(aui_pkg::CTRL_RST, rdata);
        wr(4'h9, 8'hA5);
        rd(4'h9);
        chk(8'h00, rdata);
        wr(aui_pkg::CTRL_ADDR, 8'h01 << aui_pkg::CTRL_AIE_BIT);
        acase(8'h30, 8'h59, 8'h18, 8'h80);
        st(7'h30, 7'h59, 7'h18, 7'h07);
        st(7'h31, 7'h59, 7'h18, 7'h07);
        st(7'h30, 7'h59, 7'h18, 7'h08);
        acase(8'h80, 8'h00, 8'h07, 8'h80);
        st(bcd($urandom % 60), 7'h00, 7'h07, 7'h09);
        st(bcd($urandom % 60), 7'h00, 7'h07, 7'h09);
        st(7'h00, 7'h01, 7'h07, 7'h09);
        wr(aui_pkg::CTRL_ADDR, (8'h01 << aui_pkg::CTRL_AIE_BIT) | (8'h01 << aui_pkg::CTRL_WEEKDAY_OR_MONTHDAY_SELECT_BIT));
        acase(8'h00, 8'h30, 8'h80, 8'h15);
        h1 = $urandom % 24;
        st(7'h00, 7'h30, bcd(h1), 7'h15);
        st(7'h00, 7'h31, bcd(h1), 7'h15);
        st(7'h00, 7'h30, bcd((h1 + 1) % 24), 7'h15);
        st(7'h00, 7'h30, bcd(h1), 7'h16);
        wr(aui_pkg::IRQ_MASK_ADDR, 8'h01 << aui_pkg::IRQ_UPD_BIT);
        rd(aui_pkg::IRQ_STAT_ADDR);
        wr(aui_pkg::FLAG_ADDR, 8'h03);
        chk_state();
        for (int sel = 0; sel < 2; sel++) begin
            wr(aui_pkg::CTRL_ADDR, 8'(1 | (sel << aui_pkg::CTRL_UPDATE_PERIOD_SELECT_BIT)));
            wr(aui_pkg::FLAG_ADDR, 8'h00);
            tick(sel == 0);
            chk_state();
            tick(sel == 1);
            repeat (2) @(posedge core_clk_in);
            #1 chk_pin(1'b0);
            repeat (REL - 2) @(posedge core_clk_in);
            #1 chk_pin(1'b0);
            @(posedge core_clk_in);
            #1 chk_pin(1'b1);
            chk_state();
            wr(aui_pkg::FLAG_ADDR, 8'h02);
            chk_state();
        end
        chk({7'h00, 1'b1}, {7'h00, irq_out});
        rd(aui_pkg::IRQ_STAT_ADDR);
        chk(8'h02, rdata & 8'h02);
        chk({7'h00, 1'b0}, {7'h00, irq_out});
        wr(aui_pkg::CTRL_ADDR, 8'h00);
        wr(aui_pkg::FLAG_ADDR, 8'h00);
        tick(1'b0);
        repeat (3) @(posedge core_clk_in);
        #1 chk_pin(1'b1);
        chk_state();
        wr(aui_pkg::CTRL_ADDR, 8'h01 << aui_pkg::CTRL_AIE_BIT);
        acase(8'h00, 8'h30, 8'h80, 8'h7F);
        st(7'h00, 7'h30, 7'h07, 7'h09);
        acase(8'h00, 8'h30, 8'h80, 8'h00);
        st(7'h00, 7'h30, 7'h07, 7'h09);
        stop_test();
    end
endmodule
